// >>> dv/cmr_core_test.sv
`timescale 1ns/1ps
module cmr_core_test;
    logic              clk, rst_n, op_valid, op_sel, op_dest, push_en;
    cmr_pkg::cmr_op_t  op_code;
    logic [1:0]        op_mode;
    logic [7:0]        op_lit, mem_rdata, mem_wdata, acc, option, int_ctl;
    logic [15:0]       push_val, stack_top, mem_addr, ptr0, ptr1;
    logic              op_ready, stack_pop, mem_we, mem_re, soft_reset, sw_reset_flag;
    logic [2:0]        status;
    logic [4:0]        bank_sel;
    logic [6:0]        page_latch;
    logic [14:0]       pc;
    int                n_errors, compares;
    cmr_core i_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_sel(op_sel), .op_mode(op_mode), .op_lit(op_lit), .op_dest(op_dest),
        .stack_top(stack_top), .mem_rdata(mem_rdata), .op_ready(op_ready),
        .stack_pop(stack_pop), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .acc(acc), .status(status), .bank_sel(bank_sel),
        .page_latch(page_latch), .option(option), .int_ctl(int_ctl), .ptr0(ptr0),
        .ptr1(ptr1), .pc(pc), .soft_reset(soft_reset), .sw_reset_flag(sw_reset_flag));
    cmr_mem_model i_mem (.clk(clk), .rst_n(rst_n), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .stack_pop(stack_pop), .stack_top(stack_top), .push_en(push_en), .push_val(push_val));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Offer one instruction once the core is idle; returns 1 ns after the take edge
    task automatic do_op(input cmr_pkg::cmr_op_t c, input logic s, input logic [1:0] m,
                         input logic [7:0] l, input logic d);
        int i;
        for (i = 0; i < 8 && op_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 8) begin
            n_errors++;
            finish_test();
        end
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_sel <= s;
        op_mode <= m;
        op_lit <= l;
        op_dest <= d;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_literals();
        logic [14:0] p;
        logic [2:0]  st;
        chk("option_rst", option, 16'h00FF);
        st = status;
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, 8'hFF, 0);
        chk("acc", acc, 16'h00FF);
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, 8'h5A, 0);
        chk("acc", acc, 16'h005A);
        chk("status", status, st);
        do_op(cmr_pkg::CMR_OP_LOAD_BANK, 0, 0, 8'h0F, 0);
        chk("bank", bank_sel, 16'h000F);
        do_op(cmr_pkg::CMR_OP_LOAD_PAGE, 0, 0, 8'h7F, 0);
        chk("page", page_latch, 16'h007F);
        do_op(cmr_pkg::CMR_OP_OPTION, 0, 0, 8'h00, 0);
        chk("option", option, 16'h005A);
        p = pc;
        do_op(cmr_pkg::CMR_OP_NOP, 0, 0, 8'h00, 0);
        chk("nop_pc", pc, p + 15'h0001);
        chk("nop_acc", acc, 16'h005A);
        chk("status", status, st);
    endtask
    task automatic t_store(input logic s);
        logic [15:0] p, o, nw, ea;
        logic [2:0]  st;
        logic [1:0]  m;
        for (int k = 0; k < 4; k++) begin
            m = 2'(k) ^ 2'h1;
            do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, 8'h10 + 8'(k), 0);
            p = s ? ptr1 : ptr0;
            o = s ? ptr0 : ptr1;
            st = status;
            nw = p + (m[0] ? 16'hFFFF : 16'h0001);
            ea = m[1] ? p : nw;
            do_op(cmr_pkg::CMR_OP_STORE_IND, s, m, 8'h00, 0);
            chk("we", mem_we, 1);
            chk("addr", mem_addr, ea);
            chk("wdata", mem_wdata, 16'h0010 + 16'(k));
            chk("ptr", s ? ptr1 : ptr0, nw);
            chk("other_ptr", s ? ptr0 : ptr1, o);
            chk("status", status, st);
        end
        p = s ? ptr1 : ptr0;
        do_op(cmr_pkg::CMR_OP_STORE_IND_OFS, s, 2'h2, 8'h20, 0);
        chk("ofs_addr", mem_addr, p - 16'h0020);
        chk("ofs_ptr", s ? ptr1 : ptr0, p);
    endtask
    // Store at the pointer with a post step, read back by offset and by a pre step
    task automatic t_load(input logic [7:0] v, input logic [7:0] ofs);
        logic [15:0] q, qs;
        q = ptr0;
        qs = ofs[5] ? q + 16'h0001 : q - 16'h0001;
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, v, 0);
        do_op(cmr_pkg::CMR_OP_STORE_IND, 0, ofs[5] ? 2'h2 : 2'h3, 8'h00, 0);
        chk("st_ptr", ptr0, qs);
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, ~v, 0);
        do_op(cmr_pkg::CMR_OP_LOAD_IND_OFS, 0, 0, ofs, 0);
        chk("ofs_ld_re", mem_re, 1);
        chk("ofs_ld_addr", mem_addr, q);
        step();
        chk("ofs_ld_acc", acc, {8'h00, v});
        chk("ofs_ld_ptr", ptr0, qs);
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, ~v, 0);
        do_op(cmr_pkg::CMR_OP_LOAD_IND, 0, ofs[5] ? 2'h1 : 2'h0, 8'h00, 0);
        chk("ld_addr", mem_addr, q);
        step();
        chk("ld_acc", acc, {8'h00, v});
        chk("ld_zero", {15'h0000, status[2]}, {15'h0000, v == 8'h00});
        chk("ld_ptr", ptr0, q);
    endtask
    task automatic t_rotate();
        logic [7:0] a;
        do_op(cmr_pkg::CMR_OP_LOAD_LIT, 0, 0, 8'hE6, 0);
        do_op(cmr_pkg::CMR_OP_STORE_FILE, 0, 0, 8'h7F, 0);
        chk("file_we", mem_we, 1);
        chk("file_addr", mem_addr, 16'h007F);
        do_op(cmr_pkg::CMR_OP_ROT_LEFT, 0, 0, 8'h7F, 0);
        chk("file_re", mem_re, 1);
        chk("file_rd", mem_rdata, 16'h00E6);
        a = mem_addr[7:0];
        step();
        chk("rot_l_acc", acc, 16'h00CC);
        chk("rot_l_c", status, 16'h0001);
        do_op(cmr_pkg::CMR_OP_ROT_RIGHT, 0, 0, 8'h7F, 1);
        step();
        step();
        chk("rot_r_file", i_mem.mem[a], 16'h00F3);
        chk("rot_r_acc", acc, 16'h00CC);
        chk("rot_r_c", status, 16'h0000);
    endtask
    task automatic t_returns();
        logic [15:0] v [3] = '{16'h1234, 16'h0456, 16'h7ABC};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            push_en <= 1'b1;
            push_val <= v[k];
        end
        @(posedge clk);
        push_en <= 1'b0;
        do_op(cmr_pkg::CMR_OP_RETLIT, 0, 0, 8'h3C, 0);
        chk("pop", stack_pop, 1);
        chk("busy", op_ready, 0);
        step();
        chk("lit_ret_pc", pc, 16'h7ABC);
        chk("lit_ret_acc", acc, 16'h003C);
        do_op(cmr_pkg::CMR_OP_RETFI, 0, 0, 8'h00, 0);
        chk("pop", stack_pop, 1);
        step();
        chk("int_ret_pc", pc, 16'h0456);
        chk("int_en", int_ctl[7], 1);
        do_op(cmr_pkg::CMR_OP_RETURN, 0, 0, 8'h00, 0);
        chk("busy", op_ready, 0);
        step();
        chk("ret_pc", pc, 16'h1234);
        chk("ret_int_ctl", int_ctl, 16'h0080);
        chk("ret_status", status, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        {rst_n, op_valid, op_sel, op_dest, push_en} = '0;
        {op_mode, op_lit, push_val} = '0;
        op_code = cmr_pkg::CMR_OP_NOP;
        n_errors = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("swr_flag", sw_reset_flag, 1);
        t_literals();
        t_store(0);
        t_store(1);
        t_load(8'h00, 8'h3F);
        t_load(8'h81, 8'h01);
        t_rotate();
        t_returns();
        do_op(cmr_pkg::CMR_OP_RESET, 0, 0, 8'h00, 0);
        chk("soft_reset", soft_reset, 1);
        chk("swr_flag", sw_reset_flag, 0);
        finish_test();
    end
endmodule

// >>> dv/cmr_mem_model.sv
`timescale 1ns/1ps
module cmr_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    input  wire logic        stack_pop,
    output logic      [15:0] stack_top,
    input  wire logic        push_en,
    input  wire logic [15:0] push_val
);
    logic [7:0]  mem [0:255];
    logic [15:0] stk [0:7];
    logic [2:0]  sp_reg;
    logic [7:0]  junk_reg;
    ////////////////////////////////////////////////////////////////
    // Read data only in the read cycle, a changing pattern otherwise
    assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : junk_reg;
    assign stack_top = (sp_reg == 3'h0) ? ~stk[0] : stk[sp_reg - 3'h1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= 3'h0;
            junk_reg <= 8'hA5;
        end else begin
            junk_reg <= ~junk_reg;
            sp_reg <= sp_reg + {2'h0, push_en} - {2'h0, stack_pop};
        end
    end
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
        if (push_en) begin
            stk[sp_reg] <= push_val;
        end
    end
endmodule

// >>> rtl/cmr_core.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "cmr_defines.svh"
module cmr_core (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                op_valid,
    input  wire cmr_pkg::cmr_op_t    op_code,
    input  wire logic                op_sel,
    input  wire logic [1:0]          op_mode,
    input  wire logic [7:0]          op_lit,
    input  wire logic                op_dest,
    input  wire logic [15:0]         stack_top,
    input  wire logic [7:0]          mem_rdata,
    output logic                     op_ready,
    output logic                     stack_pop,
    output logic                     mem_we,
    output logic                     mem_re,
    output logic [15:0]              mem_addr,
    output logic [7:0]               mem_wdata,
    output logic [7:0]               acc,
    output logic [2:0]               status,
    output logic [4:0]               bank_sel,
    output logic [6:0]               page_latch,
    output logic [7:0]               option,
    output logic [7:0]               int_ctl,
    output logic [15:0]              ptr0,
    output logic [15:0]              ptr1,
    output logic [14:0]              pc,
    output logic                     soft_reset,
    output logic                     sw_reset_flag
);
    ////////////////////////////////////////////////////////////////////////
    // State
    cmr_pkg::cmr_state_t state_reg;
    cmr_pkg::cmr_state_t state_next;
    cmr_pkg::cmr_op_t    op_q;
    logic                dest_q;
    logic                sel_q;
    logic [7:0]          lit_q;

    wire logic          take = op_valid && (state_reg == cmr_pkg::CMR_ST_IDLE);
    wire logic [15:0]   ptr_cur = op_sel ? ptr1 : ptr0;
    wire logic          is_ind_ld = (op_code == cmr_pkg::CMR_OP_LOAD_IND) ||
                                    (op_code == cmr_pkg::CMR_OP_LOAD_IND_OFS);
    wire logic          is_ind_st = (op_code == cmr_pkg::CMR_OP_STORE_IND) ||
                                    (op_code == cmr_pkg::CMR_OP_STORE_IND_OFS);
    wire logic          is_ofs = (op_code == cmr_pkg::CMR_OP_LOAD_IND_OFS) ||
                                 (op_code == cmr_pkg::CMR_OP_STORE_IND_OFS);
    wire logic          is_file = (op_code == cmr_pkg::CMR_OP_STORE_FILE) ||
                                  (op_code == cmr_pkg::CMR_OP_ROT_LEFT) ||
                                  (op_code == cmr_pkg::CMR_OP_ROT_RIGHT);
    wire logic          is_pop = (op_code == cmr_pkg::CMR_OP_RETFI) ||
                                 (op_code == cmr_pkg::CMR_OP_RETURN) ||
                                 (op_code == cmr_pkg::CMR_OP_RETLIT);
    wire logic [15:0]   eff_addr;
    wire logic [15:0]   ptr_upd;

    ////////////////////////////////////////////////////////////////////////
    // Pointer arithmetic
    cmr_ptr_unit #(.PW(16)) u_ptr (
        .ptr     (ptr_cur),
        .mode    (op_mode),
        .use_ofs (is_ofs),
        .ofs     (op_lit[5:0]),
        .addr    (eff_addr),
        .ptr_new (ptr_upd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Rotate datapath, uses data read in the same RD cycle
    wire logic       carry = status[`CMR_STAT_C];
    wire logic [7:0] rot_l = {mem_rdata[6:0], carry};
    wire logic [7:0] rot_r = {carry, mem_rdata[7:1]};
    wire logic       rot_is_l = (op_q == cmr_pkg::CMR_OP_ROT_LEFT);
    wire logic [7:0] rot_res = rot_is_l ? rot_l : rot_r;
    wire logic       rot_c = rot_is_l ? mem_rdata[7] : mem_rdata[0];
    wire logic       rd_rot = (state_reg == cmr_pkg::CMR_ST_RD) &&
                              (op_q != cmr_pkg::CMR_OP_LOAD_IND) &&
                              (op_q != cmr_pkg::CMR_OP_LOAD_IND_OFS);
    wire logic       rd_ld = (state_reg == cmr_pkg::CMR_ST_RD) && !rd_rot;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cmr_pkg::CMR_ST_IDLE: begin
                if (take && (is_ind_ld || op_code == cmr_pkg::CMR_OP_ROT_LEFT ||
                             op_code == cmr_pkg::CMR_OP_ROT_RIGHT)) begin
                    state_next = cmr_pkg::CMR_ST_RD;
                end else if (take && is_pop) begin
                    state_next = cmr_pkg::CMR_ST_POP;
                end
            end
            cmr_pkg::CMR_ST_RD:  state_next = cmr_pkg::CMR_ST_IDLE;
            cmr_pkg::CMR_ST_POP: state_next = cmr_pkg::CMR_ST_IDLE;
            default:             state_next = cmr_pkg::CMR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= cmr_pkg::CMR_ST_IDLE;
            op_q      <= cmr_pkg::CMR_OP_NOP;
            dest_q    <= 1'b0;
            sel_q     <= 1'b0;
            lit_q     <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (take) begin
                op_q   <= op_code;
                dest_q <= op_dest;
                sel_q  <= op_sel;
                lit_q  <= op_lit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
            mem_addr  <= 16'h0000;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            if (take && is_ind_st) begin
                mem_we    <= 1'b1;
                mem_addr  <= eff_addr;
                mem_wdata <= acc;
            end else if (take && is_ind_ld) begin
                mem_re   <= 1'b1;
                mem_addr <= eff_addr;
            end else if (take && op_code == cmr_pkg::CMR_OP_STORE_FILE) begin
                mem_we    <= 1'b1;
                mem_addr  <= {9'h000, op_lit[6:0]};
                mem_wdata <= acc;
            end else if (take && is_file) begin
                mem_re   <= 1'b1;
                mem_addr <= {9'h000, op_lit[6:0]};
            end else if (rd_rot && dest_q) begin
                mem_we    <= 1'b1;
                mem_wdata <= rot_res;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc        <= `CMR_RST_ACC;
            status     <= `CMR_RST_STATUS;
            bank_sel   <= `CMR_RST_BANK;
            page_latch <= `CMR_RST_PAGE;
            option     <= `CMR_RST_OPTION;
            int_ctl    <= `CMR_RST_INTCTL;
            ptr0       <= `CMR_RST_PTR;
            ptr1       <= `CMR_RST_PTR;
        end else begin
            if (take && (is_ind_ld || is_ind_st) && !op_sel) begin
                ptr0 <= ptr_upd;
            end
            if (take && (is_ind_ld || is_ind_st) && op_sel) begin
                ptr1 <= ptr_upd;
            end
            if (take) begin
                case (op_code)
                    cmr_pkg::CMR_OP_LOAD_BANK: bank_sel <= {1'b0, op_lit[3:0]};
                    cmr_pkg::CMR_OP_LOAD_PAGE: page_latch <= op_lit[6:0];
                    cmr_pkg::CMR_OP_LOAD_LIT:  acc <= op_lit;
                    cmr_pkg::CMR_OP_OPTION:    option <= acc;
                    cmr_pkg::CMR_OP_RETLIT:    acc <= op_lit;
                    cmr_pkg::CMR_OP_RETFI:     int_ctl[`CMR_INT_EN_BIT] <= 1'b1;
                    default: ;
                endcase
            end
            if (rd_ld) begin
                acc                 <= mem_rdata;
                status[`CMR_STAT_Z] <= (mem_rdata == 8'h00);
            end
            if (rd_rot) begin
                status[`CMR_STAT_C] <= rot_c;
                if (!dest_q) begin
                    acc <= rot_res;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter, stack pop, software reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc            <= `CMR_RST_PC;
            stack_pop     <= 1'b0;
            soft_reset    <= 1'b0;
            sw_reset_flag <= 1'b1;
            op_ready      <= 1'b0;
        end else begin
            stack_pop  <= take && is_pop;
            soft_reset <= take && (op_code == cmr_pkg::CMR_OP_RESET);
            if (take && op_code == cmr_pkg::CMR_OP_RESET) begin
                sw_reset_flag <= 1'b0;
            end
            op_ready <= (state_next == cmr_pkg::CMR_ST_IDLE);
            if (state_reg == cmr_pkg::CMR_ST_POP) begin
                pc <= stack_top[14:0];
            end else if (take) begin
                pc <= pc + 15'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_lit_acc_load: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_LOAD_LIT |=> acc == $past(op_lit))
        else $error("literal not loaded into accumulator");
    a_ptr_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
        take && is_ind_st |=> $stable(status))
        else $error("status changed by indirect store");
    a_pop_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        take && is_pop |=> stack_pop ##1 (pc == $past(stack_top[14:0])))
        else $error("return did not load pc in two cycles");
    a_int_en_set: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_RETFI |=> int_ctl[`CMR_INT_EN_BIT])
        else $error("interrupt enable not set");
    a_bank_load: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_LOAD_BANK |=> bank_sel == {1'b0, $past(op_lit[3:0])})
        else $error("bank selector wrong");
    a_page_load: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_LOAD_PAGE |=> page_latch == $past(op_lit[6:0]))
        else $error("page latch wrong");
    a_store_ind: assert property (@(posedge clk) disable iff (!rst_n)
        take && is_ind_st |=> mem_we && mem_addr == $past(eff_addr))
        else $error("indirect store address wrong");
    a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        take && is_ind_st && !is_ofs && !op_sel && op_mode[0] == 1'b0 && ptr0 == 16'hFFFF
        |=> ptr0 == 16'h0000)
        else $error("pointer did not wrap");
    a_option_load: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_OPTION |=> option == $past(acc))
        else $error("option register not loaded");
    a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
        take && op_code == cmr_pkg::CMR_OP_RESET |=> soft_reset && !sw_reset_flag)
        else $error("software reset not signalled");
endmodule

// >>> rtl/cmr_defines.svh
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH

// Pointer update modes
`define CMR_MM_PREINC     2'b00
`define CMR_MM_PREDEC     2'b01
`define CMR_MM_POSTINC    2'b10
`define CMR_MM_POSTDEC    2'b11

// Field positions and widths
`define CMR_INT_EN_BIT    7
`define CMR_STAT_C        0
`define CMR_STAT_DC       1
`define CMR_STAT_Z        2
`define CMR_BANK_W        5
`define CMR_PAGE_W        7
`define CMR_FILE_W        7
`define CMR_OFS_W         6

// Reset values
`define CMR_RST_ACC       8'h00
`define CMR_RST_STATUS    3'h0
`define CMR_RST_BANK      5'h00
`define CMR_RST_PAGE      7'h00
`define CMR_RST_OPTION    8'hFF
`define CMR_RST_INTCTL    8'h00
`define CMR_RST_PTR       16'h0000
`define CMR_RST_PC        15'h0000

`endif

// >>> rtl/cmr_pkg.sv
package cmr_pkg;
    typedef enum logic [3:0] {
        CMR_OP_NOP,
        CMR_OP_LOAD_IND,
        CMR_OP_STORE_IND,
        CMR_OP_LOAD_IND_OFS,
        CMR_OP_STORE_IND_OFS,
        CMR_OP_LOAD_BANK,
        CMR_OP_LOAD_PAGE,
        CMR_OP_LOAD_LIT,
        CMR_OP_STORE_FILE,
        CMR_OP_OPTION,
        CMR_OP_RESET,
        CMR_OP_RETFI,
        CMR_OP_RETURN,
        CMR_OP_RETLIT,
        CMR_OP_ROT_LEFT,
        CMR_OP_ROT_RIGHT
    } cmr_op_t;

    typedef enum logic [1:0] {
        CMR_ST_IDLE,
        CMR_ST_RD,
        CMR_ST_POP
    } cmr_state_t;
endpackage

// >>> rtl/cmr_ptr_unit.sv
`timescale 1ns/1ps
`include "cmr_defines.svh"
module cmr_ptr_unit #(
    parameter int PW = 16
) (
    input  wire logic [PW-1:0] ptr,
    input  wire logic [1:0]    mode,
    input  wire logic          use_ofs,
    input  wire logic [5:0]    ofs,
    output logic      [PW-1:0] addr,
    output logic      [PW-1:0] ptr_new
);
    if (PW != 16) begin : g_bad_width
        $error("pointer width must be 16");
    end

    wire logic [PW-1:0] ptr_inc = ptr + PW'(1);
    wire logic [PW-1:0] ptr_dec = ptr - PW'(1);
    wire logic [PW-1:0] ofs_ext = {{(PW-6){ofs[5]}}, ofs};
    wire logic [PW-1:0] ptr_step =
        (mode == `CMR_MM_PREINC || mode == `CMR_MM_POSTINC) ? ptr_inc : ptr_dec;
    wire logic          pre = (mode == `CMR_MM_PREINC) || (mode == `CMR_MM_PREDEC);

    assign addr    = use_ofs ? ptr + ofs_ext : (pre ? ptr_step : ptr);
    assign ptr_new = use_ofs ? ptr : ptr_step;
endmodule
